// File: panel_video_timing_packer_tb.sv
// Self-checking bench for the panel video timing packer
`timescale 1ns/1ps
module panel_video_timing_packer_tb;
  import pvtp_pkg::*;
  localparam int unsigned ST = 20;
  localparam int unsigned CC = 30;
  typedef struct {int act; int blk; logic ea; logic eh;} pvtp_row_s;
  pvtp_row_s rows[6] = '{'{480, 70, 0, 0}, '{480, 60, 0, 0}, '{480, 100, 0, 0},
                         '{479, 70, 1, 0}, '{481, 70, 1, 0}, '{480, 59, 0, 1}};
  logic ref_clk, rstn, pan_ready, mains_present_input, off_state_compensation;
  logic vid_tick, vid_de, vid_hsync, vid_vsync, vid_ready, comp_done, pan_valid;
  logic video_ok, startup_done, err_active, err_hblank, err_frame, lit;
  logic [1:0] pattern_sel_pins;
  logic [LANES*WORD_W-1:0] vid_words;
  logic [OUT_W-1:0] pan_word;
  int fails, checked, n, sd;
  pvtp_top #(.STARTUP_CYCLES(ST), .COMP_CYCLES(CC), .LOSS_CYCLES(2000)) pvtp_top_i (
    .ref_clk(ref_clk), .rstn(rstn), .vid_tick(vid_tick), .vid_de(vid_de),
    .vid_hsync(vid_hsync), .vid_vsync(vid_vsync), .vid_words(vid_words),
    .vid_ready(vid_ready), .pattern_sel_pins(pattern_sel_pins),
    .mains_present_input(mains_present_input), .off_state_compensation(off_state_compensation),
    .comp_done(comp_done), .pan_valid(pan_valid), .pan_ready(pan_ready), .pan_word(pan_word),
    .video_ok(video_ok), .startup_done(startup_done), .err_active(err_active),
    .err_hblank(err_hblank), .err_frame(err_frame));
  pvtp_host_model pvtp_host_model_i (.ref_clk(ref_clk), .vid_tick(vid_tick),
    .vid_de(vid_de), .vid_hsync(vid_hsync), .vid_vsync(vid_vsync), .vid_words(vid_words));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset();
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(|{pan_valid, comp_done, startup_done, err_active, err_hblank}, 1'b0);
    rstn = 1'b1;
  endtask : do_reset
  task automatic wait_comp(output int k);
    k = 0;
    while (comp_done !== 1'b1 && k < 200) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : wait_comp
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    pan_ready = 1'b1;
    mains_present_input = 1'b0;
    off_state_compensation = 1'b0;
    pattern_sel_pins = 2'h0;
    fails = 0;
    checked = 0;
    foreach (rows[i]) begin
      do_reset();
      pvtp_host_model_i.send(rows[i].act, rows[i].blk, 3);
      check(err_active, rows[i].ea);
      check(err_hblank, rows[i].eh);
      check(err_frame, 1'b0);
    end
    // Two short frames: the second frame edge judges the first one
    do_reset();
    repeat (2) pvtp_host_model_i.send(480, 70, 2);
    check(err_frame, 1'b1);
    check(video_ok, 1'b0);
    check(vid_ready, 1'b1);
    // Start-up black, then black or pattern by the pins, with stalls
    for (int p = 0; p < 2; p++) begin
      pattern_sel_pins = p[0] ? 2'h3 : 2'h0;
      do_reset();
      lit = 1'b0;
      sd = -1;
      for (n = 0; n < 400; n++) begin
        @(negedge ref_clk);
        if (pan_valid && !startup_done) check(|pan_word[OUT_DE-1:0], 1'b0);
        if (pan_valid && startup_done) lit = lit | (|pan_word[OUT_DE-1:0]);
        if (startup_done && sd < 0) sd = n + 1;
        pan_ready = (n % 5) != 3;
      end
      check(sd inside {[ST-1:ST+6]}, 1'b1);
      check(lit, p[0]);
    end
    // Compensation needs both enable and mains
    pan_ready = 1'b1;
    off_state_compensation = 1'b1;
    repeat (CC + 10) @(negedge ref_clk);
    check(comp_done, 1'b0);
    mains_present_input = 1'b1;
    wait_comp(n);
    check(n inside {[CC:CC+8]}, 1'b1);
    off_state_compensation = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(comp_done, 1'b0);
    off_state_compensation = 1'b1;
    wait_comp(n);
    check(comp_done, 1'b1);
    mains_present_input = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(comp_done, 1'b0);
    // Power returns before the run ends: enable stays high, count starts over
    mains_present_input = 1'b1;
    repeat (CC / 2) @(negedge ref_clk);
    check(comp_done, 1'b0);
    mains_present_input = 1'b0;
    repeat (8) @(negedge ref_clk);
    mains_present_input = 1'b1;
    wait_comp(n);
    check(n inside {[CC:CC+8]}, 1'b1);
    results();
  end
endmodule : panel_video_timing_packer_tb

// File: pvtp_checker.sv
// Port assertions for the panel video timing packer
`timescale 1ns/1ps
module pvtp_checker #(
  parameter int unsigned STARTUP_CYCLES = 20,
  parameter int unsigned COMP_CYCLES = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Pins
  input wire logic off_state_compensation,
  input wire logic mains_present_input,
  input wire logic comp_done,
  // Panel stream
  input wire logic pan_valid,
  input wire logic pan_ready,
  input wire logic [pvtp_pkg::OUT_W-1:0] pan_word,
  // Status
  input wire logic startup_done,
  input wire logic err_active,
  input wire logic err_hblank
);
  import pvtp_pkg::*;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [31:0] run_r;
  logic [31:0] up_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Saturate so a long run never wraps into a false early figure
  always_ff @(posedge ref_clk) begin
    if (!rstn || !(off_state_compensation && mains_present_input)) run_r <= '0;
    else if (run_r != '1) run_r <= run_r + 32'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) up_r <= '0;
    else if (up_r != '1) up_r <= up_r + 32'h1;
  end
  sequence s_comp_off;
    !(off_state_compensation && mains_present_input) [*8];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_comp_off_low: assert property (s_comp_off |-> !comp_done)
    else $error("comp_done high without enable and mains");
  chk_comp_too_early: assert property ($rose(comp_done) |-> run_r >= COMP_CYCLES)
    else $error("comp_done rose before the compensation time");
  chk_start_too_early: assert property ($rose(startup_done) |-> up_r >= STARTUP_CYCLES)
    else $error("startup_done rose too early");
  chk_start_too_late: assert property (up_r == STARTUP_CYCLES + 6 |-> startup_done)
    else $error("startup_done late");
  chk_start_black: assert property (pan_valid && !startup_done |-> pan_word[OUT_DE-1:0] == '0)
    else $error("non-black pixel during start-up");
  chk_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !pan_valid && !comp_done && !startup_done)
    else $error("outputs active after reset edge");
  chk_err_act_sticky: assert property (err_active |=> err_active)
    else $error("err_active cleared without reset");
  chk_err_hb_sticky: assert property (err_hblank |=> err_hblank)
    else $error("err_hblank cleared without reset");
  chk_word_stands: assert property (pan_valid && !pan_ready |=> pan_valid && $stable(pan_word))
    else $error("panel word changed while stalled");
endmodule : pvtp_checker
bind pvtp_top pvtp_checker #(.STARTUP_CYCLES(STARTUP_CYCLES), .COMP_CYCLES(COMP_CYCLES))
  pvtp_checker_i (.ref_clk(ref_clk), .rstn(rstn),
  .off_state_compensation(off_state_compensation), .mains_present_input(mains_present_input),
  .comp_done(comp_done), .pan_valid(pan_valid), .pan_ready(pan_ready), .pan_word(pan_word),
  .startup_done(startup_done), .err_active(err_active), .err_hblank(err_hblank));

// File: pvtp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pvtp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Streams
  pvtp_stream_if.snk wr,
  pvtp_stream_if.src rd
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two >= 2");
  end
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic full;
  logic empty;
  assign empty = (wp_r == rp_r);
  assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wp_r <= '0;
    end else if (wr.valid && !full) begin
      mem_r[wp_r[AW-1:0]] <= wr.data;
      wp_r <= wp_r + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rp_r <= '0;
    end else if (rd.ready && !empty) begin
      rp_r <= rp_r + 1'b1;
    end
  end
endmodule : pvtp_fifo

// File: pvtp_host_model.sv
// Host timing generator model driving the packer's video inputs
`timescale 1ns/1ps
module pvtp_host_model (
  // Clock
  input wire logic ref_clk,
  // Video
  output logic vid_tick,
  output logic vid_de,
  output logic vid_hsync,
  output logic vid_vsync,
  output logic [pvtp_pkg::LANES*pvtp_pkg::WORD_W-1:0] vid_words
);
  import pvtp_pkg::*;
  int ph;
  // Idle and defined until a send is requested
  initial begin
    ph = 0;
    vid_tick = 1'b0;
    vid_de = 1'b0;
    vid_hsync = 1'b0;
    vid_vsync = 1'b0;
    vid_words = '0;
  end
  function automatic logic [31:0] pack(input logic [9:0] v);
    return {v[1:0], v[1:0], v[1:0], 2'h3, v[9:2], v[9:2], v[9:2]};
  endfunction : pack
  // Three ticks per ten cycles gives a 75 MHz pixel clock
  task automatic px(input logic de, input int c);
    @(negedge ref_clk);
    vid_tick = 1'b1;
    vid_de = de;
    for (int k = 0; k < LANES; k++) vid_words[32*k +: 32] = pack(10'(c * 4 + k));
    @(negedge ref_clk);
    vid_tick = 1'b0;
    vid_words = ~vid_words;
    repeat ((ph == 2) ? 2 : 1) @(negedge ref_clk);
    ph = (ph == 2) ? 0 : ph + 1;
  endtask : px
  task automatic send(input int act, input int blk, input int lines);
    for (int j = 0; j < 120; j++) px(1'b0, 0);
    for (int i = 0; i < lines; i++) begin
      vid_vsync = (i == 0);
      for (int j = 0; j < act; j++) px(1'b1, j);
      for (int j = 0; j < blk; j++) begin
        vid_hsync = (j < 8);
        px(1'b0, 0);
      end
    end
  endtask : send
endmodule : pvtp_host_model

// File: pvtp_pkg.sv
// Shared constants for the panel video timing packer
package pvtp_pkg;
  // ----------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned STARTUP_MS = 3000;
  localparam int unsigned STARTUP_CYC = STARTUP_MS * CLK_KHZ / 1000 * 1000;
  localparam int unsigned COMP_MS = 5000;
  localparam int unsigned COMP_CYC = COMP_MS * (CLK_KHZ / 1000) * 1000;
  localparam int unsigned LOSS_US = 4000;
  localparam int unsigned LOSS_CYC = LOSS_US * (CLK_KHZ / 1000);
  // ----------------------------------------------------------------
  // Line and frame timing, in pixel clocks and lines
  // ----------------------------------------------------------------
  localparam int unsigned LANES = 4;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned PIX_W = 30;
  localparam logic [9:0] H_ACTIVE = 10'd480;
  localparam logic [9:0] H_BLANK_MIN = 10'd60;
  localparam logic [9:0] H_BLANK_TYP = 10'd70;
  localparam logic [9:0] H_BLANK_MAX = 10'd100;
  localparam logic [10:0] V_ACTIVE = 11'd1080;
  localparam logic [10:0] V_BLANK_TYP = 11'd45;
  localparam logic [8:0] VB120_MIN = 9'd44;
  localparam logic [8:0] VB120_MAX = 9'd46;
  localparam logic [8:0] VB100_MIN = 9'd252;
  localparam logic [8:0] VB100_MAX = 9'd276;
  localparam int unsigned GAP_W = 18;
  // Frame gap in clocks: blank lines times line length plus one line blank
  // Worked in 32 bits first: the narrow operands would overflow on their own
  localparam logic [GAP_W-1:0] GAP120_MIN = GAP_W'(int'(VB120_MIN)
      * (int'(H_ACTIVE) + int'(H_BLANK_MIN)) + int'(H_BLANK_MIN));
  localparam logic [GAP_W-1:0] GAP120_MAX = GAP_W'(int'(VB120_MAX)
      * (int'(H_ACTIVE) + int'(H_BLANK_MAX)) + int'(H_BLANK_MAX));
  localparam logic [GAP_W-1:0] GAP100_MIN = GAP_W'(int'(VB100_MIN)
      * (int'(H_ACTIVE) + int'(H_BLANK_MIN)) + int'(H_BLANK_MIN));
  localparam logic [GAP_W-1:0] GAP100_MAX = GAP_W'(int'(VB100_MAX)
      * (int'(H_ACTIVE) + int'(H_BLANK_MAX)) + int'(H_BLANK_MAX));
  // ----------------------------------------------------------------
  // Output word layout: flags above the four pixels
  // ----------------------------------------------------------------
  localparam int unsigned OUT_W = LANES * PIX_W + 3;
  localparam int unsigned OUT_DE = LANES * PIX_W;
  localparam int unsigned OUT_LS = LANES * PIX_W + 1;
  localparam int unsigned OUT_FS = LANES * PIX_W + 2;
  localparam int unsigned FIFO_DEPTH = 4;
  typedef enum logic [1:0] {PVTP_SRC_BLACK, PVTP_SRC_PATTERN, PVTP_SRC_LIVE} pvtp_src_e;
endpackage : pvtp_pkg

// File: pvtp_stream_if.sv
// Valid/ready word stream between the packer and its FIFO
`timescale 1ns/1ps
interface pvtp_stream_if #(parameter int unsigned W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pvtp_stream_if

// File: pvtp_top.sv
// Panel video timing checker, unpacker and start-up/compensation control
`timescale 1ns/1ps
module pvtp_top #(
  parameter int unsigned STARTUP_CYCLES = pvtp_pkg::STARTUP_CYC,
  parameter int unsigned COMP_CYCLES = pvtp_pkg::COMP_CYC,
  parameter int unsigned LOSS_CYCLES = pvtp_pkg::LOSS_CYC,
  parameter int unsigned DEPTH = pvtp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Video from the link receiver, one pixel clock per tick
  input wire logic vid_tick,
  input wire logic vid_de,
  input wire logic vid_hsync,
  input wire logic vid_vsync,
  input wire logic [pvtp_pkg::LANES*pvtp_pkg::WORD_W-1:0] vid_words,
  output logic vid_ready,
  // Pins
  input wire logic [1:0] pattern_sel_pins,
  input wire logic mains_present_input,
  input wire logic off_state_compensation,
  output logic comp_done,
  // Panel side stream
  output logic pan_valid,
  input wire logic pan_ready,
  output logic [pvtp_pkg::OUT_W-1:0] pan_word,
  // Status
  output logic video_ok,
  output logic startup_done,
  output logic err_active,
  output logic err_hblank,
  output logic err_frame
);
  import pvtp_pkg::*;
  if (STARTUP_CYCLES < 1 || COMP_CYCLES < 1 || LOSS_CYCLES < 1) begin : g_bad_counts
    $error("Counts must be >= 1");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PIX_W-1:0] unpack_word(input logic [WORD_W-1:0] w);
    unpack_word = {w[7:0], w[31:30], w[15:8], w[29:28], w[23:16], w[27:26]};
  endfunction : unpack_word

  function automatic logic gap_ok(input logic [GAP_W-1:0] g);
    gap_ok = (g >= GAP120_MIN && g <= GAP120_MAX) || (g >= GAP100_MIN && g <= GAP100_MAX);
  endfunction : gap_ok

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] pin_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= {pattern_sel_pins, mains_present_input, off_state_compensation};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 4; i++) begin
        if (s2_r[i] == s3_r[i]) pin_r[i] <= s3_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Start-up black period
  // ----------------------------------------------------------------
  logic [31:0] start_cnt_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      start_cnt_r <= '0;
    end else if (start_cnt_r != STARTUP_CYCLES) begin
      start_cnt_r <= start_cnt_r + 32'h0000_0001;
    end
  end
  assign startup_done = (start_cnt_r == STARTUP_CYCLES);

  // ----------------------------------------------------------------
  // Off-state compensation handshake
  // ----------------------------------------------------------------
  logic [31:0] comp_cnt_r;
  logic comp_done_r;
  // Runs only while mains is present; a drop restarts it, since the host
  // is expected to keep the enable high and simply cycle power
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      comp_cnt_r <= '0;
      comp_done_r <= 1'b0;
    end else if (!pin_r[0] || !pin_r[1]) begin
      comp_cnt_r <= '0;
      comp_done_r <= 1'b0;
    end else if (comp_cnt_r == COMP_CYCLES - 1) begin
      comp_done_r <= 1'b1;
    end else begin
      comp_cnt_r <= comp_cnt_r + 32'h0000_0001;
    end
  end
  assign comp_done = comp_done_r;

  // ----------------------------------------------------------------
  // Timing check, framed by display enable alone (syncs unused)
  // ----------------------------------------------------------------
  logic de_q_r;
  logic [9:0] act_cnt_r;
  logic [GAP_W-1:0] blank_cnt_r;
  logic [10:0] line_cnt_r;
  logic seen_frame_r;
  logic bad_r;
  logic err_act_r;
  logic err_hb_r;
  logic err_fr_r;
  logic frame_good_r;
  logic rise;
  logic fall;
  logic frame_edge;
  assign rise = vid_tick && vid_de && !de_q_r;
  assign fall = vid_tick && !vid_de && de_q_r;
  assign frame_edge = rise && (blank_cnt_r > GAP_W'(H_BLANK_MAX));
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      de_q_r <= 1'b0;
      act_cnt_r <= '0;
      blank_cnt_r <= '0;
    end else if (vid_tick) begin
      de_q_r <= vid_de;
      if (vid_de) begin
        act_cnt_r <= de_q_r ? act_cnt_r + 10'h001 : 10'h001;
      end else if (&blank_cnt_r == 1'b0 || de_q_r) begin
        blank_cnt_r <= de_q_r ? GAP_W'(1) : blank_cnt_r + GAP_W'(1);
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      line_cnt_r <= '0;
      seen_frame_r <= 1'b0;
    end else if (frame_edge) begin
      line_cnt_r <= 11'h001;
      seen_frame_r <= 1'b1;
    end else if (rise) begin
      line_cnt_r <= line_cnt_r + 11'h001;
    end
  end
  // Line errors set their flags at once and mark the frame; frame results are published at the next frame edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bad_r <= 1'b0;
      err_act_r <= 1'b0;
      err_hb_r <= 1'b0;
      err_fr_r <= 1'b0;
      frame_good_r <= 1'b0;
    end else if (frame_edge) begin
      err_fr_r <= seen_frame_r && (line_cnt_r != V_ACTIVE || !gap_ok(blank_cnt_r));
      frame_good_r <= seen_frame_r && !bad_r && line_cnt_r == V_ACTIVE && gap_ok(blank_cnt_r);
      bad_r <= 1'b0;
    end else if (fall && act_cnt_r != H_ACTIVE) begin
      bad_r <= 1'b1;
      err_act_r <= 1'b1;
    end else if (rise && (blank_cnt_r < GAP_W'(H_BLANK_MIN))) begin
      bad_r <= 1'b1;
      err_hb_r <= 1'b1;
    end
  end
  assign err_active = err_act_r;
  assign err_hblank = err_hb_r;
  assign err_frame = err_fr_r;

  // ----------------------------------------------------------------
  // Loss of input
  // ----------------------------------------------------------------
  logic [31:0] idle_cnt_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idle_cnt_r <= '0;
    end else if (vid_tick && vid_de) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != LOSS_CYCLES) begin
      idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
    end
  end
  assign video_ok = frame_good_r && (idle_cnt_r != LOSS_CYCLES);

  // ----------------------------------------------------------------
  // Source choice and internal raster
  // ----------------------------------------------------------------
  pvtp_src_e src;
  always_comb begin
    if (!startup_done) src = PVTP_SRC_BLACK;
    else if (video_ok) src = PVTP_SRC_LIVE;
    else if (pin_r[3:2] == 2'b00) src = PVTP_SRC_BLACK;
    else src = PVTP_SRC_PATTERN;
  end

  pvtp_stream_if #(.W(OUT_W)) push_if ();
  pvtp_stream_if #(.W(OUT_W)) pop_if ();

  // Black and pattern frames are paced by FIFO acceptance, not by a pixel
  // clock, so their rate follows the panel side
  logic [9:0] gen_h_r;
  logic [10:0] gen_v_r;
  logic gen_step;
  logic gen_de;
  assign gen_step = (src != PVTP_SRC_LIVE) && push_if.ready;
  assign gen_de = (gen_h_r < H_ACTIVE) && (gen_v_r < V_ACTIVE);
  always_ff @(posedge ref_clk) begin
    if (!rstn || src == PVTP_SRC_LIVE) begin
      gen_h_r <= '0;
      gen_v_r <= '0;
    end else if (gen_step) begin
      if (gen_h_r == H_ACTIVE + H_BLANK_TYP - 10'h001) begin
        gen_h_r <= '0;
        gen_v_r <= (gen_v_r == V_ACTIVE + V_BLANK_TYP - 11'h001) ? '0 : gen_v_r + 11'h001;
      end else begin
        gen_h_r <= gen_h_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO push: live words unpacked, or generated words
  // ----------------------------------------------------------------
  logic [LANES*PIX_W-1:0] live_pix;
  logic [LANES*PIX_W-1:0] gen_pix;
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      live_pix[l*PIX_W +: PIX_W] = unpack_word(vid_words[l*WORD_W +: WORD_W]);
      gen_pix[l*PIX_W +: PIX_W] = (src == PVTP_SRC_PATTERN && gen_de) ?
                                  {3{gen_h_r}} : '0;
    end
  end
  always_comb begin
    if (src == PVTP_SRC_LIVE) begin
      push_if.valid = vid_tick;
      push_if.data = {frame_edge, rise, vid_de, live_pix};
    end else begin
      push_if.valid = 1'b1;
      push_if.data = {gen_de && gen_h_r == 10'h000 && gen_v_r == 11'h000,
                      gen_de && gen_h_r == 10'h000, gen_de, gen_pix};
    end
  end
  // Live input is dropped while not shown, so the receiver never stalls then
  assign vid_ready = (src == PVTP_SRC_LIVE) ? push_if.ready : 1'b1;

  pvtp_fifo #(.W(OUT_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr(push_if),
    .rd(pop_if)
  );

  // ----------------------------------------------------------------
  // Panel output register slice
  // ----------------------------------------------------------------
  logic pan_valid_r;
  logic [OUT_W-1:0] pan_word_r;
  assign pop_if.ready = !pan_valid_r || pan_ready;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pan_valid_r <= 1'b0;
      pan_word_r <= '0;
    end else if (pop_if.ready) begin
      pan_valid_r <= pop_if.valid;
      if (pop_if.valid) pan_word_r <= pop_if.data;
    end
  end
  assign pan_valid = pan_valid_r;
  assign pan_word = pan_word_r;
endmodule : pvtp_top
